// File: core/sdp_pkg.sv
// Shared constants, command codes and pin encoding for the memory pin link
package sdp_pkg;

  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int BUS_W = 16;
  localparam int LANE_W = 8;
  localparam int PRE_BIT = 10;
  localparam int COL_X4_HI_BIT = 11;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAS_LAT = 2;
  localparam int RD_MASK_LAT = 2;
  localparam int FIFO_DEPTH = 32;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;

  // Pin codes, ordered {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n}
  localparam logic [3:0] PINS_DESELECT = 4'hF;
  localparam logic [3:0] PINS_NOP = 4'h7;
  localparam logic [3:0] PINS_ACT = 4'h3;
  localparam logic [3:0] PINS_RD = 4'h5;
  localparam logic [3:0] PINS_WR = 4'h4;
  localparam logic [3:0] PINS_PRE = 4'h2;
  localparam logic [3:0] PINS_MODE = 4'h0;
  localparam logic [3:0] PINS_REF = 4'h1;
  localparam logic [3:0] PINS_STOP = 4'h6;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MODE, CMD_REF, CMD_STOP
  } sdp_cmd_type;

  typedef enum logic [1:0] {CFG_X4, CFG_X8, CFG_X16} sdp_cfg_type;

  function automatic sdp_cmd_type sdp_decode(input logic [3:0] pins);
    sdp_cmd_type c;
    c = CMD_NOP;
    if (!pins[3]) begin
      unique case (pins[2:0])
        PINS_ACT[2:0]: c = CMD_ACT;
        PINS_RD[2:0]: c = CMD_RD;
        PINS_WR[2:0]: c = CMD_WR;
        PINS_PRE[2:0]: c = CMD_PRE;
        PINS_MODE[2:0]: c = CMD_MODE;
        PINS_REF[2:0]: c = CMD_REF;
        PINS_STOP[2:0]: c = CMD_STOP;
        PINS_NOP[2:0]: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [3:0] sdp_encode(input sdp_cmd_type c);
    logic [3:0] p;
    p = PINS_DESELECT;
    unique case (c)
      CMD_NOP: p = PINS_NOP;
      CMD_ACT: p = PINS_ACT;
      CMD_RD: p = PINS_RD;
      CMD_WR: p = PINS_WR;
      CMD_PRE: p = PINS_PRE;
      CMD_MODE: p = PINS_MODE;
      CMD_REF: p = PINS_REF;
      CMD_STOP: p = PINS_STOP;
    endcase
    return p;
  endfunction

endpackage

// File: core/sdp_if.sv
// Pin link between the memory controller end and the memory device end
`timescale 1ns/1ns
`default_nettype none
interface sdp_if;
  logic chip_select_n;
  logic row_strobe_n;
  logic column_strobe_n;
  logic write_enable_n;
  logic [sdp_pkg::BANK_W-1:0] bank_select;
  logic [sdp_pkg::ADDR_W-1:0] addr_bus;
  logic low_byte_mask;
  logic high_byte_mask;
  logic [sdp_pkg::BUS_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [sdp_pkg::BUS_W-1:0] dev_dq;
  logic [1:0] dev_dq_oe;
  logic [sdp_pkg::BUS_W-1:0] data_bus;

  // Wire level per byte lane; an undriven lane reads as zero
  assign data_bus[7:0] = dev_dq_oe[0] ? dev_dq[7:0] : (ctl_dq_oe ? ctl_dq[7:0] : 8'h00);
  assign data_bus[15:8] = dev_dq_oe[1] ? dev_dq[15:8] : (ctl_dq_oe ? ctl_dq[15:8] : 8'h00);

  modport ctl (
    output chip_select_n, row_strobe_n, column_strobe_n, write_enable_n,
    output bank_select, addr_bus, low_byte_mask, high_byte_mask, ctl_dq, ctl_dq_oe,
    input data_bus
  );
  modport dev (
    input chip_select_n, row_strobe_n, column_strobe_n, write_enable_n,
    input bank_select, addr_bus, low_byte_mask, high_byte_mask, data_bus,
    output dev_dq, dev_dq_oe
  );
endinterface
`default_nettype wire

// File: core/sdp_dev.sv
// Memory device end: command decode, bank rows, masked writes, masked reads
`timescale 1ns/1ns
`default_nettype none
module sdp_dev #(
  parameter sdp_pkg::sdp_cfg_type CFG = sdp_pkg::CFG_X16,
  parameter int ROW_BITS = 2,
  parameter int COL_BITS = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_en,
  sdp_if.dev link,
  output logic [sdp_pkg::ADDR_W-1:0] mode_code,
  output logic [sdp_pkg::NUM_BANKS-1:0] bank_open,
  output logic access_miss
);

  localparam int IDX_W = sdp_pkg::BANK_W + ROW_BITS + COL_BITS;
  localparam int DEPTH = 1 << IDX_W;
  localparam int LAT = sdp_pkg::CAS_LAT;
  localparam int MLAT = sdp_pkg::RD_MASK_LAT;

  // Data lanes that exist in this configuration
  localparam logic [sdp_pkg::BUS_W-1:0] BUS_USED =
    (CFG == sdp_pkg::CFG_X4) ? 16'h000F :
    (CFG == sdp_pkg::CFG_X8) ? 16'h00FF : 16'hFFFF;
  localparam logic [1:0] LANE_USED = (CFG == sdp_pkg::CFG_X16) ? 2'h3 : 2'h1;

  sdp_pkg::sdp_cmd_type cmd;
  logic [sdp_pkg::ADDR_W-1:0] col_addr;
  logic [1:0] lane_mask;
  logic [IDX_W-1:0] idx;
  logic [sdp_pkg::ADDR_W-1:0] row_reg [sdp_pkg::NUM_BANKS];
  logic [sdp_pkg::NUM_BANKS-1:0] open_reg;
  logic [sdp_pkg::BUS_W-1:0] rd_word;
  logic [LAT-1:0] rd_valid_reg;
  logic [sdp_pkg::BUS_W-1:0] rd_data_reg [LAT];
  logic [1:0] mask_pipe_reg [MLAT];
  logic [sdp_pkg::ADDR_W-1:0] mode_reg;
  logic miss_reg;
  logic bank_hit;

  // Pins are decoded combinationally here and take effect only in the clocked processes below
  assign cmd = sdp_pkg::sdp_decode({link.chip_select_n, link.row_strobe_n,
                                    link.column_strobe_n, link.write_enable_n});

  // A deselected chip decodes as no operation, so only new commands are dropped

  always_comb begin
    col_addr = '0;
    unique case (CFG)
      sdp_pkg::CFG_X4: begin
        col_addr[9:0] = link.addr_bus[9:0];
        col_addr[10] = link.addr_bus[sdp_pkg::COL_X4_HI_BIT];
      end
      sdp_pkg::CFG_X8: begin
        col_addr[9:0] = link.addr_bus[9:0];
      end
      sdp_pkg::CFG_X16: begin
        col_addr[8:0] = link.addr_bus[8:0];
      end
    endcase
  end

  always_comb begin
    if (CFG == sdp_pkg::CFG_X16) begin
      lane_mask = {link.high_byte_mask, link.low_byte_mask};
    end else begin
      lane_mask = {link.high_byte_mask, link.high_byte_mask};
    end
  end

  // Storage index: bank, low bits of the open row, low bits of the column
  assign idx = {link.bank_select, row_reg[link.bank_select][ROW_BITS-1:0],
                col_addr[COL_BITS-1:0]};
  assign bank_hit = open_reg[link.bank_select];

  // Row open and close per bank
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      open_reg <= '0;
    end else if (clock_en) begin
      unique case (cmd)
        sdp_pkg::CMD_ACT: begin
          open_reg[link.bank_select] <= 1'b1;
        end
        sdp_pkg::CMD_RD, sdp_pkg::CMD_WR: begin
          // Burst length one: the burst ends with this command
          if (link.addr_bus[sdp_pkg::PRE_BIT]) begin
            open_reg[link.bank_select] <= 1'b0;
          end
        end
        sdp_pkg::CMD_PRE: begin
          if (link.addr_bus[sdp_pkg::PRE_BIT]) begin
            open_reg <= '0;
          end else begin
            open_reg[link.bank_select] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Row address capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int b = 0; b < sdp_pkg::NUM_BANKS; b++) begin
        row_reg[b] <= '0;
      end
    end else if (clock_en && cmd == sdp_pkg::CMD_ACT) begin
      row_reg[link.bank_select] <= link.addr_bus;
    end
  end

  // Mode register load
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= sdp_pkg::MODE_RESET;
    end else if (clock_en && cmd == sdp_pkg::CMD_MODE) begin
      mode_reg <= link.addr_bus;
    end
  end
  assign mode_code = mode_reg;

  // Write storage, one byte lane at a time
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      // Each lane owns its storage, so the two writers never share a variable
      logic [sdp_pkg::LANE_W-1:0] lane_mem_reg [DEPTH];
      always_ff @(posedge clock) begin
        if (clock_en && cmd == sdp_pkg::CMD_WR && bank_hit && LANE_USED[g]
            && !lane_mask[g]) begin
          lane_mem_reg[idx] <=
            link.data_bus[g*sdp_pkg::LANE_W +: sdp_pkg::LANE_W]
            & BUS_USED[g*sdp_pkg::LANE_W +: sdp_pkg::LANE_W];
        end
      end
      assign rd_word[g*sdp_pkg::LANE_W +: sdp_pkg::LANE_W] = lane_mem_reg[idx];
    end
  endgenerate

  // Read pipeline; data reaches the pins LAT clocks after the command
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_reg <= '0;
      for (int s = 0; s < LAT; s++) begin
        rd_data_reg[s] <= '0;
      end
    end else if (clock_en) begin
      rd_valid_reg[0] <= (cmd == sdp_pkg::CMD_RD) && bank_hit;
      rd_data_reg[0] <= rd_word & BUS_USED;
      for (int s = 1; s < LAT; s++) begin
        rd_valid_reg[s] <= rd_valid_reg[s-1];
        rd_data_reg[s] <= rd_data_reg[s-1];
      end
    end
  end

  // Mask pipeline runs every cycle that clock_en is high, whatever the chip select does
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int s = 0; s < MLAT; s++) begin
        mask_pipe_reg[s] <= '0;
      end
    end else if (clock_en) begin
      mask_pipe_reg[0] <= lane_mask;
      for (int s = 1; s < MLAT; s++) begin
        mask_pipe_reg[s] <= mask_pipe_reg[s-1];
      end
    end
  end

  assign link.dev_dq = rd_data_reg[LAT-1];
  assign link.dev_dq_oe = {2{rd_valid_reg[LAT-1]}} & ~mask_pipe_reg[MLAT-1]
                          & LANE_USED;

  // Access to a closed bank flags a miss for one cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      miss_reg <= 1'b0;
    end else if (clock_en) begin
      miss_reg <= (cmd == sdp_pkg::CMD_RD || cmd == sdp_pkg::CMD_WR) && !bank_hit;
    end
  end
  assign access_miss = miss_reg;
  assign bank_open = open_reg;

endmodule
`default_nettype wire

// File: core/sdp_ctl.sv
// Memory controller end with its read-data FIFO
`timescale 1ns/1ns
`default_nettype none
module sdp_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != D[AW:0];
  assign out_valid = cnt_reg != '0;
  assign push = in_valid && in_ready && clock_en;
  assign pop = out_valid && out_ready && clock_en;
  assign out_data = mem_reg[rd_reg];
  assign level = cnt_reg;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

module sdp_ctl #(
  parameter int DEPTH = sdp_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_en,
  sdp_if.ctl link,
  input wire logic req_valid,
  output logic req_ready,
  input wire sdp_pkg::sdp_cmd_type req_cmd,
  input wire logic [sdp_pkg::BANK_W-1:0] req_bank,
  input wire logic [sdp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sdp_pkg::BUS_W-1:0] req_wdata,
  input wire logic [1:0] req_mask,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [sdp_pkg::BUS_W-1:0] rd_data
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int PIPE = sdp_pkg::CAS_LAT + 1;

  logic [3:0] pins_reg;
  logic [sdp_pkg::BANK_W-1:0] bank_reg;
  logic [sdp_pkg::ADDR_W-1:0] addr_reg;
  logic [1:0] mask_reg;
  logic [sdp_pkg::BUS_W-1:0] wdata_reg;
  logic wr_oe_reg;
  logic [PIPE-1:0] rd_pipe_reg;
  logic [CW-1:0] level;
  logic [CW-1:0] inflight;
  logic take;

  assign inflight = CW'(rd_pipe_reg[0]) + CW'(rd_pipe_reg[1]) + CW'(rd_pipe_reg[2]);
  // Room is reserved for every read already on the link, so a capture is never refused
  assign req_ready = (level + inflight) < CW'(DEPTH);
  assign take = req_valid && req_ready && clock_en;

  // Command, address and mask pins: one command per accepted request
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg <= sdp_pkg::PINS_DESELECT;
      bank_reg <= '0;
      addr_reg <= '0;
      mask_reg <= '0;
    end else if (clock_en) begin
      pins_reg <= take ? sdp_pkg::sdp_encode(req_cmd) : sdp_pkg::PINS_DESELECT;
      bank_reg <= take ? req_bank : '0;
      addr_reg <= take ? req_addr : '0;
      mask_reg <= take ? req_mask : '0;
    end
  end

  // Write data rides with the write command
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_reg <= '0;
      wr_oe_reg <= 1'b0;
    end else if (clock_en) begin
      wdata_reg <= req_wdata;
      wr_oe_reg <= take && req_cmd == sdp_pkg::CMD_WR;
    end
  end

  // Read data is sampled CAS_LAT clocks after the command leaves the pins
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pipe_reg <= '0;
    end else if (clock_en) begin
      rd_pipe_reg <= {rd_pipe_reg[PIPE-2:0], take && req_cmd == sdp_pkg::CMD_RD};
    end
  end

  assign {link.chip_select_n, link.row_strobe_n, link.column_strobe_n,
          link.write_enable_n} = pins_reg;
  assign link.bank_select = bank_reg;
  assign link.addr_bus = addr_reg;
  assign link.low_byte_mask = mask_reg[0];
  assign link.high_byte_mask = mask_reg[1];
  assign link.ctl_dq = wdata_reg;
  assign link.ctl_dq_oe = wr_oe_reg;

  sdp_fifo #(.W(sdp_pkg::BUS_W), .D(DEPTH)) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .clock_en(clock_en),
    .in_valid(rd_pipe_reg[PIPE-1]),
    .in_ready(),
    .in_data(link.data_bus),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .level(level)
  );
endmodule
`default_nettype wire

// File: tb/sdp_props.sv
// Concurrent checks on the pin link between controller and device
`timescale 1ns/1ns
`default_nettype none
module sdp_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic ctl_dq_oe,
  input wire logic [1:0] dev_dq_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic [3:0] pins;
  assign pins = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
  sequence s_rd;
    pins == sdp_pkg::PINS_RD;
  endsequence
  sequence s_wr;
    pins == sdp_pkg::PINS_WR;
  endsequence
  property p_rd_lanes;
    logic [1:0] m;
    (s_rd, m = {high_byte_mask, low_byte_mask}) |-> ##2 dev_dq_oe == ~m;
  endproperty
  a_wr_drive_oe: assert property (s_wr |-> ctl_dq_oe)
    else $error("write cycle without controller data drive");
  a_oe_only_wr: assert property (ctl_dq_oe |-> pins == sdp_pkg::PINS_WR)
    else $error("controller drives data outside a write");
  a_rd_lane_oe: assert property (p_rd_lanes)
    else $error("read lanes do not follow the masks two clocks later");
  a_mask_lo_hz: assert property (low_byte_mask |-> ##2 !dev_dq_oe[0])
    else $error("low lane driven two clocks after its mask");
  a_mask_hi_hz: assert property (high_byte_mask |-> ##2 !dev_dq_oe[1])
    else $error("high lane driven two clocks after its mask");
  a_idle_no_data: assert property (!(pins == sdp_pkg::PINS_RD) |-> ##2 dev_dq_oe == 2'b00)
    else $error("device drives data without a read two clocks before");
  a_bus_no_clash: assert property (!(ctl_dq_oe && (dev_dq_oe != 2'b00)))
    else $error("both ends drive the data bus");
  a_deselect_strobes: assert property (chip_select_n |-> pins == sdp_pkg::PINS_DESELECT)
    else $error("strobes not idle while deselected");
endmodule
`default_nettype wire

// File: tb/sdp_cmd_addr_mask_pins_tb_top.sv
// Self-checking bench joining controller and device ends across the pin link
`timescale 1ns/1ns
`default_nettype none
module sdp_cmd_addr_mask_pins_tb_top;
  logic clock = 0, sys_rst = 1, clock_en = 1, req_valid = 0, rd_ready = 0;
  sdp_pkg::sdp_cmd_type req_cmd = sdp_pkg::CMD_NOP;
  logic [1:0] req_bank = 0, req_mask = 0;
  logic [12:0] req_addr = 0, code;
  logic [15:0] req_wdata = 0, lfsr = 16'h002d, r, rd_data;
  logic req_ready, rd_valid, access_miss;
  logic [12:0] mode_code;
  logic [3:0] bank_open;
  int errors = 0, num_checks = 0, misses = 0;
  logic [15:0] mem [0:127];
  logic [1:0] rowv [0:3];
  logic [15:0] q [$];
  logic [7:0] mem8 [0:127];
  logic [15:0] q8 [$];
  logic [1:0] rd_seen = 0;
  always #25 clock = ~clock;
  sdp_if sdp_if_inst ();
  sdp_if sdp_if_x8 ();
  sdp_ctl #(.DEPTH(32)) sdp_ctl_inst (.clock(clock), .sys_rst(sys_rst), .clock_en(clock_en),
    .link(sdp_if_inst), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  sdp_dev #(.CFG(sdp_pkg::CFG_X16)) sdp_dev_inst (.clock(clock), .sys_rst(sys_rst),
    .clock_en(clock_en), .link(sdp_if_inst), .mode_code(mode_code), .bank_open(bank_open),
    .access_miss(access_miss));
  // Byte-wide device on a copy of the same command, address, mask and write pins
  sdp_dev #(.CFG(sdp_pkg::CFG_X8)) sdp_dev_x8_inst (.clock(clock), .sys_rst(sys_rst),
    .clock_en(clock_en), .link(sdp_if_x8), .mode_code(), .bank_open(), .access_miss());
  assign {sdp_if_x8.chip_select_n, sdp_if_x8.row_strobe_n, sdp_if_x8.column_strobe_n,
    sdp_if_x8.write_enable_n, sdp_if_x8.bank_select, sdp_if_x8.addr_bus,
    sdp_if_x8.low_byte_mask, sdp_if_x8.high_byte_mask, sdp_if_x8.ctl_dq,
    sdp_if_x8.ctl_dq_oe} = {sdp_if_inst.chip_select_n, sdp_if_inst.row_strobe_n,
    sdp_if_inst.column_strobe_n, sdp_if_inst.write_enable_n, sdp_if_inst.bank_select,
    sdp_if_inst.addr_bus, sdp_if_inst.low_byte_mask, sdp_if_inst.high_byte_mask,
    sdp_if_inst.ctl_dq, sdp_if_inst.ctl_dq_oe};
  sdp_props sdp_props_inst (.clock(clock), .sys_rst(sys_rst),
    .chip_select_n(sdp_if_inst.chip_select_n), .row_strobe_n(sdp_if_inst.row_strobe_n),
    .column_strobe_n(sdp_if_inst.column_strobe_n), .write_enable_n(sdp_if_inst.write_enable_n),
    .low_byte_mask(sdp_if_inst.low_byte_mask), .high_byte_mask(sdp_if_inst.high_byte_mask),
    .ctl_dq_oe(sdp_if_inst.ctl_dq_oe), .dev_dq_oe(sdp_if_inst.dev_dq_oe));
  always @(posedge clock) begin
    if (access_miss === 1'b1) misses <= misses + 1;
  end
  // Byte-wide read word stands on the bus two cycles after its command
  always begin
    @(posedge clock);
    #2;
    if (rd_seen[1] === 1'b1) chk(sdp_if_x8.data_bus, q8.pop_front());
    rd_seen = {rd_seen[0], {sdp_if_x8.chip_select_n, sdp_if_x8.row_strobe_n,
      sdp_if_x8.column_strobe_n, sdp_if_x8.write_enable_n} == sdp_pkg::PINS_RD};
  end
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request stays up until accepted; the caller drops it with idle
  task req(input sdp_pkg::sdp_cmd_type c, input logic [1:0] b, input logic [12:0] a,
    input logic [15:0] d, input logic [1:0] m);
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_wdata = d;
    req_mask = m;
    req_valid = 1;
    while (req_ready !== 1'b1) begin
      @(posedge clock);
      #2;
    end
    @(posedge clock);
    #2;
  endtask
  task idle(input int n);
    req_valid = 0;
    repeat (n) begin
      @(posedge clock);
      #2;
    end
  endtask
  // Model keeps unmasked lanes; mask bit 1 is the high lane
  task wr(input logic [1:0] b, input logic [12:0] a, input logic [15:0] d, input logic [1:0] m);
    if (!m[0]) mem[{b, rowv[b], a[2:0]}][7:0] = d[7:0];
    if (!m[1]) mem[{b, rowv[b], a[2:0]}][15:8] = d[15:8];
    if (!m[1]) mem8[{b, rowv[b], a[2:0]}] = d[7:0];
    req(sdp_pkg::CMD_WR, b, a & 13'h1bff, d, m);
  endtask
  task rd(input logic [1:0] b, input logic [12:0] a, input logic [1:0] m);
    q.push_back(mem[{b, rowv[b], a[2:0]}] & {{8{!m[1]}}, {8{!m[0]}}});
    q8.push_back({8'h00, mem8[{b, rowv[b], a[2:0]}] & {8{!m[1]}}});
    req(sdp_pkg::CMD_RD, b, a & 13'h1bff, 16'h0000, m);
  endtask
  // Drain with a stalling consumer
  task drain;
    while (q.size() > 0) begin
      r = rnd();
      rd_ready = r[0];
      if (rd_ready && rd_valid === 1'b1) chk(rd_data, q.pop_front());
      @(posedge clock);
      #2;
    end
    rd_ready = 0;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    #2;
    sys_rst = 0;
    chk(bank_open, 16'h0000);
    chk(mode_code, 16'h0000);
    r = rnd();
    code = r[12:0];
    req(sdp_pkg::CMD_MODE, 2'b00, code, 16'h0000, 2'b00);
    idle(2);
    chk(mode_code, code);
    for (int b = 0; b < 4; b++) begin
      r = rnd();
      rowv[b] = r[1:0];
      req(sdp_pkg::CMD_ACT, b[1:0], r[12:0], 16'h0000, 2'b00);
    end
    idle(2);
    chk(bank_open, 16'h000f);
    for (int i = 0; i < 32; i++) wr(i[4:3], {10'h000, i[2:0]}, rnd(), 2'b00);
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      wr(r[4:3], r[15:3], rnd(), r[1:0]);
    end
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      rd(r[1:0], r[15:3], r[14:13]);
    end
    idle(4);
    chk(req_ready, 16'h0000);
    drain;
    req(sdp_pkg::CMD_REF, 2'b00, 13'h0400, 16'h0000, 2'b00);
    req(sdp_pkg::CMD_STOP, 2'b00, 13'h0400, 16'h0000, 2'b00);
    req(sdp_pkg::CMD_NOP, 2'b00, 13'h0400, 16'h0000, 2'b00);
    idle(2);
    chk(bank_open, 16'h000f);
    req(sdp_pkg::CMD_PRE, 2'b01, 13'h0000, 16'h0000, 2'b00);
    idle(2);
    chk(bank_open, 16'h000d);
    q.push_back(16'h0000);
    q8.push_back(16'h0000);
    req(sdp_pkg::CMD_RD, 2'b01, 13'h0000, 16'h0000, 2'b11);
    q.push_back(mem[{2'b10, rowv[2], 3'h0}]);
    q8.push_back({8'h00, mem8[{2'b10, rowv[2], 3'h0}]});
    req(sdp_pkg::CMD_RD, 2'b10, 13'h0400, 16'h0000, 2'b00);
    idle(4);
    chk(misses[15:0], 16'h0001);
    chk(bank_open, 16'h0009);
    drain;
    req(sdp_pkg::CMD_PRE, 2'b00, 13'h0400, 16'h0000, 2'b00);
    // Frozen clock enable: the standing precharge is not seen until it returns
    clock_en = 0;
    idle(3);
    chk(bank_open, 16'h0009);
    clock_en = 1;
    idle(2);
    chk(bank_open, 16'h0000);
    chk(16'(q8.size()), 16'h0000);
    final_report;
  end
  initial begin
    #1000000;
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
